/* File: ipp_dibits.sv */
// Module: packs pin 4 and pin 2 levels into the two-byte input bit field
module ipp_dibits #(
  parameter int N = 8
) (
  // Pin levels, one bit per port
  input wire logic [N-1:0] pin4,
  input wire logic [N-1:0] pin2,
  // Ordering select, low for port-based
  input wire logic pin_based,
  // Field, byte 3 in the low half
  output logic [2*N-1:0] field
);
  for (genvar i = 0; i < N; i++) begin : g_port
    // Port-based pairs: pin 4 even, pin 2 odd
    wire pb_even = pin4[i];
    wire pb_odd = pin2[i];
    // Pin-based halves: pin 4 of port j in bit j, pin 2 of port j in bit N+j
    assign field[2*i] = pin_based ? ((2*i < N) ? pin4[2*i % N] :
                        pin2[2*i % N]) : pb_even;
    assign field[2*i+1] = pin_based ? ((2*i+1 < N) ? pin4[(2*i+1) % N] :
                          pin2[(2*i+1) % N]) : pb_odd;
  end
endmodule

/* File: ipp_fifo.sv */
// Module: flip-flop FIFO with valid/ready on both sides
module ipp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire full = (cnt_q == (AW + 1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] wr_nxt = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
  wire [AW-1:0] rd_nxt = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

  // Frozen clock enable also blocks both handshakes
  assign in_ready = ce && !full;
  assign out_valid = ce && !empty;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;

  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[e] <= '0;
      end else if (push && wr_q == AW'(e)) begin
        mem_q[e] <= in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= wr_nxt;
      if (pop) rd_q <= rd_nxt;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

/* File: ipp_packer.sv */
// Module: input process image packer with APB control and byte stream out
//
// Local design decisions: register access over APB and the address map.
module ipp_packer #(
  parameter int DEPTH = ipp_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // IO-Link engine, upper ports
  input wire ipp_pkg::ipp_port_in_t port_six_in,
  input wire ipp_pkg::ipp_port_in_t port_seven_in,
  input wire ipp_pkg::ipp_port_in_t port_eight_in,
  // Port pins, asynchronous
  input wire logic [ipp_pkg::N_PORTS-1:0] pin4_sensed_input,
  input wire logic [ipp_pkg::N_PORTS-1:0] pin2_sensed_input,
  // Driven output levels, same clock
  input wire logic [ipp_pkg::N_PORTS-1:0] pin4_driven_output,
  input wire logic [ipp_pkg::N_PORTS-1:0] pin2_driven_output,
  // Image byte stream
  output logic img_valid,
  input wire logic img_ready,
  output ipp_pkg::ipp_beat_t img_beat
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [ipp_pkg::N_PORTS-1:0] pin4_meta_q;
  logic [ipp_pkg::N_PORTS-1:0] pin4_sync_q;
  logic [ipp_pkg::N_PORTS-1:0] pin2_meta_q;
  logic [ipp_pkg::N_PORTS-1:0] pin2_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin4_meta_q <= '0;
      pin4_sync_q <= '0;
      pin2_meta_q <= '0;
      pin2_sync_q <= '0;
    end else if (ce) begin
      pin4_meta_q <= pin4_sensed_input;
      pin4_sync_q <= pin4_meta_q;
      pin2_meta_q <= pin2_sensed_input;
      pin2_sync_q <= pin2_meta_q;
    end
  end

  // ****************************************************************
  // APB register file
  // ****************************************************************
  logic auto_q;
  logic layout_q;
  logic start_req_q;
  logic ctrl_written_q;
  logic [ipp_pkg::MODE_W-1:0] mode_q;
  logic [ipp_pkg::N_PORTS-1:0] pin4_dir_q;
  logic [ipp_pkg::N_PORTS-1:0] pin2_dir_q;
  logic [7:0] frame_cnt_q;
  logic [31:0] prdata_q;
  ipp_pkg::ipp_state_t state_q;
  logic fifo_in_ready;

  wire setup = ce && psel && !penable;
  wire access = ce && psel && penable;
  wire hit_ctrl = (paddr == ipp_pkg::ADDR_CTRL);
  wire hit_mode = (paddr == ipp_pkg::ADDR_MODE);
  wire hit_pindir = (paddr == ipp_pkg::ADDR_PINDIR);
  wire hit_status = (paddr == ipp_pkg::ADDR_STATUS);
  wire mapped = hit_ctrl || hit_mode || hit_pindir || hit_status;
  wire wr = access && pwrite && mapped;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_start = wr_ctrl && pwdata[ipp_pkg::CTRL_START];
  wire busy = (state_q == ipp_pkg::IPP_SEND);

  wire [31:0] rd_ctrl = 32'(
    {layout_q, auto_q, start_req_q});
  wire [31:0] rd_mode = 32'(mode_q);
  wire [31:0] rd_pindir = 32'({pin2_dir_q, pin4_dir_q});
  wire [31:0] rd_status = 32'(
    {frame_cnt_q, 6'h00, !fifo_in_ready, busy});
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_mode ? rd_mode :
                       hit_pindir ? rd_pindir :
                       hit_status ? rd_status : 32'h0000_0000;

  // Zero wait states; a frozen block stretches the access phase
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= 1'b0;
      layout_q <= 1'b0;
      ctrl_written_q <= 1'b0;
    end else if (wr_ctrl) begin
      auto_q <= pwdata[ipp_pkg::CTRL_AUTO];
      layout_q <= pwdata[ipp_pkg::CTRL_LAYOUT];
      ctrl_written_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= ipp_pkg::MODE_RESET;
      pin4_dir_q <= ipp_pkg::PINDIR_RESET[7:0];
      pin2_dir_q <= ipp_pkg::PINDIR_RESET[15:8];
    end else begin
      if (wr && hit_mode) mode_q <= pwdata[ipp_pkg::MODE_W-1:0];
      if (wr && hit_pindir) begin
        pin4_dir_q <= pwdata[7:0];
        pin2_dir_q <= pwdata[15:8];
      end
    end
  end

  // ****************************************************************
  // Field bits and image assembly
  // ****************************************************************
  // Configured outputs report their driven level instead of the pin
  wire [ipp_pkg::N_PORTS-1:0] bit4 =
    (pin4_dir_q & pin4_driven_output) | (~pin4_dir_q & pin4_sync_q);
  wire [ipp_pkg::N_PORTS-1:0] bit2 =
    (pin2_dir_q & pin2_driven_output) | (~pin2_dir_q & pin2_sync_q);
  logic [15:0] field;

  ipp_dibits #(
    .N(ipp_pkg::N_PORTS)
  ) u_dibits (
    .pin4(bit4),
    .pin2(bit2),
    .pin_based(layout_q),
    .field(field)
  );

  ipp_pkg::ipp_port_in_t upper_in [ipp_pkg::N_UPPER];
  assign upper_in[0] = port_six_in;
  assign upper_in[1] = port_seven_in;
  assign upper_in[2] = port_eight_in;

  logic [ipp_pkg::FRAME_BYTES-1:0][7:0] image_d;
  assign image_d[0] = field[7:0];
  assign image_d[1] = field[15:8];

  for (genvar p = 0; p < ipp_pkg::N_UPPER; p++) begin : g_upper
    localparam int B = ipp_pkg::IDX_UPPER + p * ipp_pkg::PORT_STRIDE;
    localparam int PIN = ipp_pkg::FIRST_UPPER + p;
    ipp_pkg::ipp_mode_t mode_w;
    assign mode_w = ipp_pkg::ipp_mode_t'(mode_q[2*p +: 2]);
    wire is_iol = (mode_w == ipp_pkg::IPP_MODE_IOL);
    wire is_di = (mode_w == ipp_pkg::IPP_MODE_DI);
    wire is_do = (mode_w == ipp_pkg::IPP_MODE_DO);
    // Digital modes: state in bit 0, rest of the block cleared
    wire pin_state = is_do ? pin4_driven_output[PIN] :
                             pin4_sync_q[PIN];
    wire [31:0] dig_word = {31'h0000_0000, pin_state};
    wire [31:0] data_w = is_iol ? upper_in[p].data :
                         (is_di || is_do) ? dig_word : 32'h0000_0000;
    assign image_d[B] = upper_in[p].qual;
    assign image_d[B+1] = 8'h00;
    for (genvar k = 0; k < 4; k++) begin : g_byte
      assign image_d[B+ipp_pkg::QUAL_TO_DATA+k] = data_w[8*k +: 8];
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  logic [ipp_pkg::FRAME_BYTES-1:0][7:0] snap_q;
  logic [ipp_pkg::IDX_W-1:0] idx_q;
  ipp_pkg::ipp_beat_t push_beat;

  wire start = ce && !busy && (start_req_q || auto_q);
  wire push_hs = busy && fifo_in_ready;
  wire last = (idx_q == ipp_pkg::IDX_W'(ipp_pkg::FRAME_BYTES - 1));
  wire lo_half = (idx_q < ipp_pkg::IDX_W'(ipp_pkg::IDX_UPPER));
  wire [7:0] off_lo = 8'(ipp_pkg::OFF_BITS + idx_q);
  wire [7:0] off_hi = 8'(ipp_pkg::OFF_Q6 + idx_q - ipp_pkg::IDX_UPPER);
  assign push_beat.offset = lo_half ? off_lo : off_hi;
  assign push_beat.data = snap_q[idx_q];

  // A start written while a frame is running waits; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_req_q <= 1'b0;
    end else if (ce) begin
      start_req_q <= wr_start || (start_req_q && !start);
    end
  end

  // Whole image taken in one edge, so no frame mixes old and new data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= '0;
    end else if (start) begin
      snap_q <= image_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ipp_pkg::IPP_IDLE;
      idx_q <= '0;
      frame_cnt_q <= 8'h00;
    end else if (ce) begin
      unique case (state_q)
        ipp_pkg::IPP_IDLE: begin
          if (start) begin
            state_q <= ipp_pkg::IPP_SEND;
            idx_q <= '0;
          end
        end
        ipp_pkg::IPP_SEND: begin
          if (push_hs && last) begin
            state_q <= ipp_pkg::IPP_IDLE;
            frame_cnt_q <= frame_cnt_q + 8'h01;
          end else if (push_hs) begin
            idx_q <= idx_q + 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  ipp_fifo #(
    .WIDTH($bits(ipp_pkg::ipp_beat_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .in_valid(busy),
    .in_ready(fifo_in_ready),
    .in_data(push_beat),
    .out_valid(img_valid),
    .out_ready(img_ready),
    .out_data(img_beat),
    .count()
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  localparam int Q6 = ipp_pkg::IDX_UPPER;
  localparam int Q7 = Q6 + ipp_pkg::PORT_STRIDE;
  localparam int Q8 = Q7 + ipp_pkg::PORT_STRIDE;
  localparam int D = ipp_pkg::QUAL_TO_DATA;

  qual_place_a: assert property (
    start |=> snap_q[Q6] == $past(port_six_in.qual) &&
      snap_q[Q7] == $past(port_seven_in.qual) &&
      snap_q[Q8] == $past(port_eight_in.qual) &&
      snap_q[Q6+1] == 8'h00 && snap_q[Q8+1] == 8'h00)
    else $error("qualifier byte misplaced");

  iol_copy_a: assert property (
    start && mode_q[1:0] == 2'h0 |=>
      snap_q[Q6+D] == $past(port_six_in.data[7:0]) &&
      snap_q[Q6+D+3] == $past(port_six_in.data[31:24]))
    else $error("port six device data not copied");

  data_offset_a: assert property (
    push_hs && last |-> push_beat.offset == 8'h34 &&
      push_beat.data == snap_q[Q8+D+3])
    else $error("port eight data block offset wrong");

  di_bit_a: assert property (
    start && mode_q[5:4] == 2'h1 |=>
      snap_q[Q8+D] == {7'h00, $past(pin4_sync_q[7])})
    else $error("digital input byte wrong");

  do_bit_a: assert property (
    start && mode_q[3:2] == 2'h2 |=>
      snap_q[Q7+D] == {7'h00, $past(pin4_driven_output[6])})
    else $error("digital output mirror wrong");

  rsv_zero_a: assert property (
    start && (mode_q[1:0] == 2'h1 || mode_q[1:0] == 2'h2) |=>
      snap_q[Q6+D+1] == 8'h00 && snap_q[Q6+D+2] == 8'h00 &&
      snap_q[Q6+D+3] == 8'h00)
    else $error("reserved data bytes not zero");

  layout_def_a: assert property (
    !ctrl_written_q |-> !layout_q)
    else $error("ordering not port-based after reset");

  port_map_a: assert property (
    start && !layout_q |=>
      snap_q[1][7:6] == $past({bit2[7], bit4[7]}) &&
      snap_q[0][1:0] == $past({bit2[0], bit4[0]}))
    else $error("port-based bit field wrong");

  pin_map_a: assert property (
    start && layout_q |=> snap_q[0] == $past(bit4) &&
      snap_q[1] == $past(bit2))
    else $error("pin-based bit field wrong");

  mirror_a: assert property (
    start && layout_q && pin4_dir_q[3] |=>
      snap_q[0][3] == $past(pin4_driven_output[3]))
    else $error("driven level not mirrored");

  frame_hold_a: assert property (
    busy |=> $stable(snap_q))
    else $error("image changed within a frame");

endmodule

/* File: ipp_pkg.sv */
// Package: constants, register map and carrier types of the image packer
//
// Overview of operation
// - Qualifier bytes of ports six, seven, eight sit at 35, 41, 47, then a zero.
// - Port six in IO-Link mode copies four device input bytes after its zero.
// - Bytes 43-46 hold port seven data, bytes 49-52 port eight data.
// - Digital input mode: bit 0 of first data byte is pin 4, bits 1-7 zero.
// - Digital output mode: bit 0 of first data byte mirrors the driven output.
// - In digital modes the three remaining data bytes stay zero.
// - Digital input bits pack port-based or pin-based; port-based after reset.
// - Port-based: each port owns two bits, pin 4 even, pin 2 odd, bytes 3-4.
// - Pin-based: pin 4 of all ports in byte 3, pin 2 in byte 4.
// - Each field bit is the sensed input or the mirrored driven output.
package ipp_pkg;

  // ****************************************************************
  // Image geometry
  // ****************************************************************
  localparam int N_PORTS = 8;
  localparam int N_UPPER = 3;
  localparam int FIRST_UPPER = 5;
  localparam int PORT_STRIDE = 6;
  localparam int IDX_UPPER = 2;
  localparam int FRAME_BYTES = IDX_UPPER + N_UPPER * PORT_STRIDE;
  localparam int IDX_W = 5;
  localparam int QUAL_TO_DATA = 2;
  localparam logic [7:0] OFF_BITS = 8'h03;
  localparam logic [7:0] OFF_Q6 = 8'h23;
  localparam logic [7:0] OFF_Q7 = 8'h29;
  localparam logic [7:0] OFF_Q8 = 8'h2F;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_PINDIR = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_LAYOUT = 2;
  localparam int MODE_W = 2 * N_UPPER;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [15:0] PINDIR_RESET = 16'h0000;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_CNT = 8;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    IPP_MODE_IOL,
    IPP_MODE_DI,
    IPP_MODE_DO,
    IPP_MODE_RSV
  } ipp_mode_t;

  typedef enum logic {
    IPP_IDLE,
    IPP_SEND
  } ipp_state_t;

  typedef struct packed {
    logic [7:0] qual;
    logic [31:0] data;
  } ipp_port_in_t;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } ipp_beat_t;

endpackage

/* File: ipp_sink.sv */
// Network controller model: takes image beats and stalls on command
module ipp_sink (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stall pattern: 0 always ready, 1 bursty, 2 held off
  input wire logic [1:0] stall,
  // Image stream
  input wire logic img_valid,
  output logic img_ready,
  input wire ipp_pkg::ipp_beat_t img_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ofs [256];
  logic [7:0] dat [256];
  int n = 0;
  logic [3:0] tick_q;

  // Ready moves only after an edge, like the real controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 4'h0;
      img_ready <= 1'b0;
    end else begin
      tick_q <= tick_q + 4'h3;
      img_ready <= (stall == 2'h0) || (stall == 2'h1 && tick_q[2]);
    end
  end

  always @(posedge pclk) begin
    if (presetn && img_valid && img_ready) begin
      ofs[n] = img_beat.offset;
      dat[n] = img_beat.data;
      n = n + 1;
    end
  end
endmodule

/* File: tb.sv */
// Testbench: APB set-up, random image frames, stream and register checks
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ipp_pkg::ipp_port_in_t p6 = '0;
  ipp_pkg::ipp_port_in_t p7 = '0;
  ipp_pkg::ipp_port_in_t p8 = '0;
  logic [7:0] i4 = 8'h00;
  logic [7:0] i2 = 8'h00;
  logic [7:0] o4 = 8'h00;
  logic [7:0] o2 = 8'h00;
  logic img_valid;
  logic img_ready;
  ipp_pkg::ipp_beat_t img_beat;
  logic [1:0] stall = 2'h0;
  logic ce = 1'b1;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int frames = 0;
  logic [31:0] rnd = 32'h8B6C3CAA;
  // Snapshot the expectations are built from
  logic [7:0] q [3];
  logic [31:0] dd [3];
  logic [7:0] s4, s2, d4, d2;
  logic [5:0] md;
  logic [15:0] pdir;
  logic lay;

  ipp_packer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_six_in(p6), .port_seven_in(p7),
    .port_eight_in(p8), .pin4_sensed_input(i4), .pin2_sensed_input(i2),
    .pin4_driven_output(o4), .pin2_driven_output(o2),
    .img_valid(img_valid), .img_ready(img_ready), .img_beat(img_beat));
  ipp_sink i_sink (.pclk(pclk), .presetn(presetn), .stall(stall),
    .img_valid(img_valid), .img_ready(img_ready), .img_beat(img_beat));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [31:0] r();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction

  function automatic logic [7:0] exp_ofs(input int i);
    return (i < 2) ? 8'(3 + i) : 8'(33 + i);
  endfunction

  function automatic logic [7:0] exp_byte(input int o);
    int j, b;
    logic [15:0] f;
    logic [7:0] p4, p2;
    p4 = (pdir[7:0] & d4) | (~pdir[7:0] & s4);
    p2 = (pdir[15:8] & d2) | (~pdir[15:8] & s2);
    for (int k = 0; k < 8; k++) begin
      if (lay) begin
        f[k] = p4[k];
        f[8+k] = p2[k];
      end else begin
        f[2*k] = p4[k];
        f[2*k+1] = p2[k];
      end
    end
    if (o == 3) return f[7:0];
    if (o == 4) return f[15:8];
    j = (o - 35) / 6;
    b = (o - 35) % 6;
    if (b == 0) return q[j];
    if (b == 1) return 8'h00;
    case (md[2*j +: 2])
      2'h0: return dd[j][8*(b-2) +: 8];
      2'h1: return (b == 2) ? {7'h00, s4[5+j]} : 8'h00;
      2'h2: return (b == 2) ? {7'h00, d4[5+j]} : 8'h00;
      default: return 8'h00;
    endcase
  endfunction

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: reg %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_beat(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: beat %h want %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Entered just after a rising edge; holds all until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic scramble();
    p6 <= {8'(r()), r()};
    p7 <= {8'(r()), r()};
    p8 <= {8'(r()), r()};
    {i4, i2, o4, o2} <= r();
  endtask

  task automatic frame(input int nr, input logic fill);
    int base, k;
    logic [31:0] rd;
    logic err;
    for (int j = 0; j < 3; j++) begin
      q[j] = 8'(r());
      dd[j] = r();
    end
    {s4, s2, d4, d2} = r();
    md = (nr < 4) ? {3{nr[1:0]}} : 6'(r());
    pdir = 16'(r());
    lay = (nr == 0) ? 1'b0 : 1'(r());
    p6 <= {q[0], dd[0]};
    p7 <= {q[1], dd[1]};
    p8 <= {q[2], dd[2]};
    {i4, i2, o4, o2} <= {s4, s2, d4, d2};
    apb(1'b1, ipp_pkg::ADDR_MODE, {26'h0, md}, rd, err);
    apb(1'b1, ipp_pkg::ADDR_PINDIR, {16'h0, pdir}, rd, err);
    apb(1'b0, ipp_pkg::ADDR_PINDIR, 32'h0, rd, err);
    cmp_reg(rd, {16'h0, pdir});
    stall <= fill ? 2'h2 : 2'(nr % 2);
    base = i_sink.n;
    apb(1'b1, ipp_pkg::ADDR_CTRL, {29'h0, lay, 2'b01}, rd, err);
    // Snapshot edge has passed: later input changes must not leak in
    scramble();
    if (nr == 6) begin
      // Frozen enable mid-frame must leave the stream intact
      ce <= 1'b0;
      repeat (5) @(posedge pclk);
      cmp_reg({31'h0, img_valid}, 32'h0);
      ce <= 1'b1;
    end
    if (fill) begin
      repeat (25) @(posedge pclk);
      apb(1'b0, ipp_pkg::ADDR_STATUS, 32'h0, rd, err);
      cmp_reg(rd, {16'h0, 8'(frames), 8'h03});
      stall <= 2'h1;
    end
    k = 0;
    while (i_sink.n < base + 20 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 20; i++) begin
      cmp_beat(i_sink.ofs[base+i], exp_ofs(i));
      cmp_beat(i_sink.dat[base+i], exp_byte(exp_ofs(i)));
      cmp_beat(i_sink.dat[base+i], exp_byte(exp_ofs(i)));
    end
    cmp_reg(32'(i_sink.n - base), 32'd20);
    frames++;
    apb(1'b0, ipp_pkg::ADDR_STATUS, 32'h0, rd, err);
    cmp_reg(rd, {16'h0, 8'(frames), 8'h00});
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] rd;
    logic err;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ipp_pkg::ADDR_CTRL, 32'h0, rd, err);
    cmp_reg(rd, 32'h0);
    apb(1'b0, ipp_pkg::ADDR_MODE, 32'h0, rd, err);
    cmp_reg(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    cmp_reg({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, rd, err);
    cmp_reg({31'h0, err}, 32'h1);
    for (int nr = 0; nr < 7; nr++) begin
      frame(nr, nr == 5);
    end
    apb(1'b1, ipp_pkg::ADDR_STATUS, 32'hFFFF, rd, err);
    apb(1'b0, ipp_pkg::ADDR_STATUS, 32'h0, rd, err);
    cmp_reg(rd, {16'h0, 8'(frames), 8'h00});
    summarize();
  end
endmodule
